/* File: rtl/wfs_params.svh */
`ifndef WFS_PARAMS_SVH
`define WFS_PARAMS_SVH
`define WFS_ST_W        3
`define WFS_RST_VAL     1'b0
`define WFS_SUP_W       3
`define WFS_SUP_WWD     0
`define WFS_SUP_FWD     1
`define WFS_SUP_ERR     2
`endif

/* File: rtl/wfs_pkg.sv */
`include "wfs_params.svh"
package wfs_pkg;
    // one-hot codes; OTHER covers the states kept elsewhere
    typedef enum logic [`WFS_ST_W-1:0] {
        WFS_OTHER    = 3'b001,
        WFS_WAKE     = 3'b010,
        WFS_FAILSAFE = 3'b100
    } wfs_state_t;
endpackage : wfs_pkg

/* File: rtl/wfs_ctrl.sv */
`include "wfs_params.svh"
module wfs_ctrl (
    input  wire logic         mclk_i,
    input  wire logic         reset_i,
    input  wire logic         in_sleep_i,
    input  wire logic         in_normal_i,
    input  wire logic         micro_supply_regulator_overcurrent_i,
    input  wire logic         wake_edge_input_i,
    input  wire logic         wake_level_input_i,
    input  wire logic         analog_builtin_self_test_i,
    input  wire logic         severe_failure_i,
    input  wire logic         spi_cs_n_i,
    input  wire logic         cmd_valid_i,
    input  wire logic         wake_request_command_i,
    input  wire logic         sleep_request_i,
    input  wire logic         standby_request_i,
    input  wire logic         cmd_standby_regulator_i,
    input  wire logic         cmd_comm_supply_regulator_i,
    input  wire logic         cmd_volt_ref_i,
    input  wire logic [1:0]   cmd_tracker_supplies_i,
    input  wire logic [2:0]   cmd_supervision_i,
    input  wire logic         cmd_set_regs_i,
    input  wire logic         cmd_set_sup_i,
    input  wire logic         normal_comm_i,
    input  wire logic         normal_volt_ref_i,
    input  wire logic [1:0]   normal_trackers_i,
    input  wire logic [2:0]   normal_supervision_i,
    input  wire logic         boost_select_pin_i,
    input  wire logic         vin_low_i,
    input  wire logic         core_adjust_select_pin_i,
    input  wire logic         power_seq_i,
    output logic              wfs_wake_o,
    output logic              wfs_failsafe_o,
    output logic              wake_irq_o,
    output logic              to_sleep_o,
    output logic              to_standby_o,
    output logic              standby_regulator_o,
    output logic              pre_regulator_buck_o,
    output logic              pre_regulator_boost_o,
    output logic              micro_supply_regulator_o,
    output logic              comm_supply_regulator_o,
    output logic              volt_ref_o,
    output logic [1:0]        tracker_supplies_o,
    output logic              core_adjust_o,
    output logic              wake_timer_en_o,
    output logic [2:0]        supervision_en_o,
    output logic              reset_out_o,
    output logic              safe_state_out_first_o,
    output logic              safe_state_out_second_o,
    output logic              safe_state_control_o
);
    import wfs_pkg::*;

    logic [1:0] cs_sync_q;
    logic [1:0] evt_a_q, evt_b_q, evt_c_q, evt_d_q;
    logic [1:0] bst_q, vin_q, sec_q;
    logic       cs_prev_q;
    logic       cs_rise;
    logic       cmd_armed_q;
    logic       go_wake, go_sleep, go_stby, wake_evt;
    wfs_state_t state_q, state_d;
    logic       core_adj_q;

    // pins from outside the clock pass two flops first
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cs_sync_q <= 2'h3;
            evt_a_q   <= 2'h0;
            evt_b_q   <= 2'h0;
            evt_c_q   <= 2'h0;
            evt_d_q   <= 2'h0;
            bst_q     <= 2'h0;
            vin_q     <= 2'h0;
            sec_q     <= 2'h0;
            cs_prev_q <= 1'b1;
        end else begin
            cs_sync_q <= {cs_sync_q[0], spi_cs_n_i};
            evt_a_q   <= {evt_a_q[0], wake_edge_input_i};
            evt_b_q   <= {evt_b_q[0], wake_level_input_i};
            evt_c_q   <= {evt_c_q[0], micro_supply_regulator_overcurrent_i};
            evt_d_q   <= {evt_d_q[0], severe_failure_i};
            bst_q     <= {bst_q[0], boost_select_pin_i};
            vin_q     <= {vin_q[0], vin_low_i};
            sec_q     <= {sec_q[0], core_adjust_select_pin_i};
            cs_prev_q <= cs_sync_q[1];
        end
    end

    assign cs_rise = cs_sync_q[1] & ~cs_prev_q;

    // a command is held until the frame closes
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cmd_armed_q <= 1'b0;
        end else if (cmd_valid_i) begin
            // a new frame's command outlives the old frame's close
            cmd_armed_q <= 1'b1;
        end else if (cs_rise) begin
            cmd_armed_q <= 1'b0;
        end
    end

    assign go_wake  = cs_rise & cmd_armed_q & wake_request_command_i;
    assign go_sleep = cs_rise & cmd_armed_q & sleep_request_i;
    assign go_stby  = cs_rise & cmd_armed_q & standby_request_i;

    assign wake_evt = in_sleep_i & (evt_a_q[1] | evt_b_q[1] | evt_c_q[1] | go_wake);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            WFS_OTHER: begin
                if (wake_evt || (in_normal_i && analog_builtin_self_test_i)) begin
                    state_d = WFS_WAKE;
                end
            end
            WFS_WAKE: begin
                if (go_sleep || go_stby) begin
                    state_d = WFS_OTHER;
                end
            end
            WFS_FAILSAFE: begin
                state_d = WFS_FAILSAFE;
            end
            default: begin
                state_d = WFS_FAILSAFE;
            end
        endcase
        if (evt_d_q[1]) begin
            state_d = WFS_FAILSAFE;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= WFS_OTHER;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            core_adj_q <= 1'b0;
        end else if (power_seq_i) begin
            core_adj_q <= sec_q[1];
        end
    end

    // status and handoff pulses
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wfs_wake_o     <= 1'b0;
            wfs_failsafe_o <= 1'b0;
            wake_irq_o     <= 1'b0;
            to_sleep_o     <= 1'b0;
            to_standby_o   <= 1'b0;
        end else begin
            wfs_wake_o     <= state_d == WFS_WAKE;
            wfs_failsafe_o <= state_d == WFS_FAILSAFE;
            wake_irq_o     <= state_d == WFS_WAKE && state_q != WFS_WAKE;
            to_sleep_o     <= state_q == WFS_WAKE && state_d == WFS_OTHER && go_sleep;
            to_standby_o   <= state_q == WFS_WAKE && state_d == WFS_OTHER && !go_sleep;
        end
    end

    // supply and supervision settings; outside wake/failsafe they hold
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            standby_regulator_o      <= 1'b0;
            pre_regulator_buck_o     <= 1'b0;
            pre_regulator_boost_o    <= 1'b0;
            micro_supply_regulator_o <= 1'b0;
            comm_supply_regulator_o  <= 1'b0;
            volt_ref_o               <= 1'b0;
            tracker_supplies_o       <= 2'h0;
            core_adjust_o            <= 1'b0;
            wake_timer_en_o          <= 1'b0;
            supervision_en_o         <= 3'h0;
            reset_out_o              <= `WFS_RST_VAL;
            safe_state_out_first_o   <= 1'b0;
            safe_state_out_second_o  <= 1'b0;
            safe_state_control_o     <= 1'b0;
        end else if (state_d == WFS_FAILSAFE) begin
            standby_regulator_o      <= 1'b0;
            pre_regulator_buck_o     <= 1'b0;
            pre_regulator_boost_o    <= 1'b0;
            micro_supply_regulator_o <= 1'b0;
            comm_supply_regulator_o  <= 1'b0;
            volt_ref_o               <= 1'b0;
            tracker_supplies_o       <= 2'h0;
            core_adjust_o            <= 1'b0;
            wake_timer_en_o          <= 1'b0;
            supervision_en_o         <= 3'h0;
            reset_out_o              <= 1'b0;
            safe_state_out_first_o   <= 1'b0;
            safe_state_out_second_o  <= 1'b0;
            safe_state_control_o     <= 1'b0;
        end else if (state_d == WFS_WAKE) begin
            if (cmd_set_regs_i) begin
                standby_regulator_o <= cmd_standby_regulator_i;
            end
            pre_regulator_buck_o     <= 1'b1;
            pre_regulator_boost_o    <= bst_q[1] & vin_q[1];
            micro_supply_regulator_o <= 1'b1;
            core_adjust_o            <= core_adj_q;
            if (state_q != WFS_WAKE) begin
                comm_supply_regulator_o <= normal_comm_i;
                volt_ref_o              <= normal_volt_ref_i;
                tracker_supplies_o      <= normal_trackers_i;
                supervision_en_o        <= normal_supervision_i;
            end else begin
                if (cmd_set_regs_i) begin
                    comm_supply_regulator_o <= cmd_comm_supply_regulator_i;
                    volt_ref_o              <= cmd_volt_ref_i;
                    tracker_supplies_o      <= cmd_tracker_supplies_i;
                end
                if (cmd_set_sup_i) begin
                    supervision_en_o <= cmd_supervision_i;
                end
            end
            wake_timer_en_o         <= 1'b0;
            reset_out_o             <= 1'b1;
            safe_state_out_first_o  <= 1'b0;
            safe_state_out_second_o <= 1'b0;
            safe_state_control_o    <= 1'b0;
        end
    end

    a_wake_irq: assert property (@(posedge mclk_i) disable iff (reset_i)
        (state_q != WFS_WAKE && state_d == WFS_WAKE) |=> wake_irq_o)
        else $error("no irq on wake entry");
    a_wake_safe: assert property (@(posedge mclk_i) disable iff (reset_i)
        wfs_wake_o |-> !safe_state_out_first_o && !safe_state_out_second_o
            && !safe_state_control_o)
        else $error("safe output high in wake");
    a_wake_timer: assert property (@(posedge mclk_i) disable iff (reset_i)
        wfs_wake_o |-> !wake_timer_en_o)
        else $error("wake timer on in wake");
    a_wake_reset: assert property (@(posedge mclk_i) disable iff (reset_i)
        wfs_wake_o |-> reset_out_o)
        else $error("reset low in wake");
    a_fs_off: assert property (@(posedge mclk_i) disable iff (reset_i)
        wfs_failsafe_o |-> !micro_supply_regulator_o && !pre_regulator_buck_o
            && !standby_regulator_o && !comm_supply_regulator_o
            && tracker_supplies_o == 2'h0 && !volt_ref_o)
        else $error("supply on in failsafe");
    a_fs_sup: assert property (@(posedge mclk_i) disable iff (reset_i)
        wfs_failsafe_o |-> supervision_en_o == 3'h0 && !wake_timer_en_o)
        else $error("supervision on in failsafe");
    a_fs_reset: assert property (@(posedge mclk_i) disable iff (reset_i)
        wfs_failsafe_o |-> !reset_out_o)
        else $error("reset high in failsafe");
    a_fs_safe: assert property (@(posedge mclk_i) disable iff (reset_i)
        wfs_failsafe_o |-> !safe_state_out_first_o && !safe_state_out_second_o
            && !safe_state_control_o)
        else $error("safe output high in failsafe");
    a_sup_restore: assert property (@(posedge mclk_i) disable iff (reset_i)
        (state_q == WFS_OTHER && state_d == WFS_WAKE)
            |=> supervision_en_o == $past(normal_supervision_i))
        else $error("supervision not restored");
    a_cs_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
        (state_q == WFS_WAKE && !cs_rise && !evt_d_q[1]) |=> state_q == WFS_WAKE)
        else $error("wake left without cs rise");
endmodule : wfs_ctrl

/* File: tb/wfs_mcu_model.sv */
module wfs_mcu_model (
    input  wire logic mclk_i,
    output logic      spi_cs_n_o,
    output logic      cmd_valid_o,
    output logic      wake_req_o,
    output logic      sleep_req_o,
    output logic      standby_req_o,
    output logic      set_regs_o,
    output logic      set_sup_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cmd_valid_o, wake_req_o, sleep_req_o, standby_req_o, set_regs_o, set_sup_o} = '0;
        spi_cs_n_o = 1'b1;
    end
    // req is {standby, sleep, wake}; levels stand until the next frame opens
    task automatic frame(input logic [2:0] req);
        @(posedge mclk_i);
        spi_cs_n_o <= 1'b0;
        {standby_req_o, sleep_req_o, wake_req_o} <= 3'h0;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b1;
        {standby_req_o, sleep_req_o, wake_req_o} <= req;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b0;
        repeat (2) @(posedge mclk_i);
        spi_cs_n_o <= 1'b1;
        repeat (2) @(posedge mclk_i);
    endtask : frame
    task automatic pulse(input bit sup);
        @(posedge mclk_i);
        if (sup) set_sup_o <= 1'b1;
        else set_regs_o <= 1'b1;
        @(posedge mclk_i);
        {set_sup_o, set_regs_o} <= 2'h0;
    endtask : pulse
endmodule : wfs_mcu_model

/* File: tb/wfs_ctrl_tb.sv */
module wfs_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic sl; int src; logic comm; logic vref; logic [1:0] trk;
        logic [2:0] sup; logic bsel; logic vlow; logic exp;
    } wfs_row_t;
    logic mclk_i, reset_i, in_sleep_i, in_normal_i, micro_supply_regulator_overcurrent_i;
    logic wake_edge_input_i, wake_level_input_i, analog_builtin_self_test_i, severe_failure_i;
    logic spi_cs_n_i, cmd_valid_i, wake_request_command_i, sleep_request_i, standby_request_i;
    logic cmd_standby_regulator_i, cmd_comm_supply_regulator_i, cmd_volt_ref_i, cmd_set_regs_i;
    logic cmd_set_sup_i, normal_comm_i, normal_volt_ref_i, boost_select_pin_i, vin_low_i;
    logic core_adjust_select_pin_i, power_seq_i;
    logic [1:0] cmd_tracker_supplies_i, normal_trackers_i, tracker_supplies_o;
    logic [2:0] cmd_supervision_i, normal_supervision_i, supervision_en_o;
    logic wfs_wake_o, wfs_failsafe_o, wake_irq_o, to_sleep_o, to_standby_o, standby_regulator_o;
    logic pre_regulator_buck_o, pre_regulator_boost_o, micro_supply_regulator_o, volt_ref_o;
    logic comm_supply_regulator_o, core_adjust_o, wake_timer_en_o, reset_out_o;
    logic safe_state_out_first_o, safe_state_out_second_o, safe_state_control_o;
    int err_count, total_checks;
    // refused cases first; the self-test row last leaves the block in wake
    wfs_row_t rows [7] = '{
        '{1'b0, 1, 1'b1, 1'b0, 2'h1, 3'h1, 1'b0, 1'b0, 1'b0},
        '{1'b0, 3, 1'b0, 1'b1, 2'h2, 3'h2, 1'b1, 1'b1, 1'b0},
        '{1'b1, 0, 1'b1, 1'b0, 2'h1, 3'h5, 1'b1, 1'b1, 1'b1},
        '{1'b1, 1, 1'b0, 1'b1, 2'h2, 3'h2, 1'b1, 1'b0, 1'b1},
        '{1'b1, 2, 1'b1, 1'b1, 2'h3, 3'h7, 1'b0, 1'b1, 1'b1},
        '{1'b1, 3, 1'b0, 1'b0, 2'h0, 3'h0, 1'b1, 1'b1, 1'b1},
        '{1'b0, 4, 1'b1, 1'b0, 2'h2, 3'h6, 1'b1, 1'b1, 1'b1}};

    wfs_ctrl wfs_ctrl_inst (.mclk_i, .reset_i, .in_sleep_i, .in_normal_i,
        .micro_supply_regulator_overcurrent_i, .wake_edge_input_i, .wake_level_input_i,
        .analog_builtin_self_test_i, .severe_failure_i, .spi_cs_n_i, .cmd_valid_i,
        .wake_request_command_i, .sleep_request_i, .standby_request_i, .cmd_standby_regulator_i,
        .cmd_comm_supply_regulator_i, .cmd_volt_ref_i, .cmd_tracker_supplies_i,
        .cmd_supervision_i, .cmd_set_regs_i, .cmd_set_sup_i, .normal_comm_i, .normal_volt_ref_i,
        .normal_trackers_i, .normal_supervision_i, .boost_select_pin_i, .vin_low_i,
        .core_adjust_select_pin_i, .power_seq_i, .wfs_wake_o, .wfs_failsafe_o, .wake_irq_o,
        .to_sleep_o, .to_standby_o, .standby_regulator_o, .pre_regulator_buck_o,
        .pre_regulator_boost_o, .micro_supply_regulator_o, .comm_supply_regulator_o, .volt_ref_o,
        .tracker_supplies_o, .core_adjust_o, .wake_timer_en_o, .supervision_en_o, .reset_out_o,
        .safe_state_out_first_o, .safe_state_out_second_o, .safe_state_control_o);
    wfs_mcu_model wfs_mcu_model_inst (.mclk_i, .spi_cs_n_o(spi_cs_n_i),
        .cmd_valid_o(cmd_valid_i), .wake_req_o(wake_request_command_i),
        .sleep_req_o(sleep_request_i), .standby_req_o(standby_request_i),
        .set_regs_o(cmd_set_regs_i), .set_sup_o(cmd_set_sup_i));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    function automatic logic pick(input int s);
        case (s)
            0: return wfs_wake_o;
            1: return to_sleep_o;
            2: return to_standby_o;
            default: return wfs_failsafe_o;
        endcase
    endfunction : pick
    task automatic wait_on(input int s);
        bit got;
        got = 1'b0;
        for (int i = 0; i < 40 && !got; i++) begin
            @(posedge mclk_i);
            #1;
            got = (pick(s) === 1'b1);
        end
        if (!got) begin
            err_count++;
            give_verdict();
        end
    endtask : wait_on
    task automatic do_reset;
        @(posedge mclk_i);
        reset_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        reset_i <= 1'b0;
        {in_normal_i, analog_builtin_self_test_i, wake_level_input_i} <= 3'h0;
        {micro_supply_regulator_overcurrent_i, wake_edge_input_i, severe_failure_i} <= 3'h0;
    endtask : do_reset
    // core pin follows comm so its value differs across rows
    task automatic apply(input wfs_row_t r);
        @(posedge mclk_i);
        {in_sleep_i, normal_comm_i, normal_volt_ref_i, normal_trackers_i} <=
            {r.sl, r.comm, r.vref, r.trk};
        {normal_supervision_i, boost_select_pin_i, vin_low_i} <= {r.sup, r.bsel, r.vlow};
        {power_seq_i, core_adjust_select_pin_i} <= {1'b1, r.comm};
        repeat (4) @(posedge mclk_i);
        {power_seq_i, core_adjust_select_pin_i} <= {1'b0, ~r.comm};
        repeat (3) @(posedge mclk_i);
        case (r.src)
            0: micro_supply_regulator_overcurrent_i <= 1'b1;
            1: wake_edge_input_i <= 1'b1;
            2: wake_level_input_i <= 1'b1;
            3: wfs_mcu_model_inst.frame(3'h1);
            default: {in_normal_i, analog_builtin_self_test_i} <= 2'h3;
        endcase
    endtask : apply
    task automatic chk_wake(input wfs_row_t r);
        chk(wake_irq_o, 1'b1);
        chk({reset_out_o, safe_state_out_first_o, safe_state_out_second_o,
             safe_state_control_o}, 4'h8);
        chk(wake_timer_en_o, 1'b0);
        chk({pre_regulator_buck_o, pre_regulator_boost_o, micro_supply_regulator_o},
            {1'b1, r.bsel & r.vlow, 1'b1});
        chk({comm_supply_regulator_o, volt_ref_o, tracker_supplies_o},
            {r.comm, r.vref, r.trk});
        chk(supervision_en_o, r.sup);
        chk(core_adjust_o, r.comm);
        @(posedge mclk_i);
        #1;
        chk(wake_irq_o, 1'b0);
    endtask : chk_wake
    task automatic cfg_wake(input logic [2:0] rg, input logic [1:0] trk, input logic [2:0] sup);
        {cmd_standby_regulator_i, cmd_comm_supply_regulator_i, cmd_volt_ref_i} <= rg;
        cmd_tracker_supplies_i <= trk;
        wfs_mcu_model_inst.pulse(1'b0);
        repeat (2) @(posedge mclk_i);
        #1;
        chk({standby_regulator_o, comm_supply_regulator_o, volt_ref_o, tracker_supplies_o},
            {rg, trk});
        cmd_supervision_i <= sup;
        wfs_mcu_model_inst.pulse(1'b1);
        repeat (2) @(posedge mclk_i);
        #1;
        chk(supervision_en_o, sup);
    endtask : cfg_wake

    initial begin
        #20000;
        err_count++;
        give_verdict();
    end
    initial begin
        reset_i = 1'b1;
        {in_sleep_i, in_normal_i, micro_supply_regulator_overcurrent_i, wake_edge_input_i} = '0;
        {wake_level_input_i, analog_builtin_self_test_i, severe_failure_i} = '0;
        {cmd_standby_regulator_i, cmd_comm_supply_regulator_i, cmd_volt_ref_i} = '0;
        {cmd_tracker_supplies_i, cmd_supervision_i, normal_comm_i, normal_volt_ref_i} = '0;
        {normal_trackers_i, normal_supervision_i, boost_select_pin_i, vin_low_i} = '0;
        {core_adjust_select_pin_i, power_seq_i} = '0;
        do_reset();
        @(posedge mclk_i);
        #1;
        chk({wfs_wake_o, wfs_failsafe_o, wake_irq_o, reset_out_o, supervision_en_o}, 7'h0);
        foreach (rows[i]) begin
            do_reset();
            apply(rows[i]);
            if (rows[i].exp) begin
                wait_on(0);
                chk_wake(rows[i]);
            end else begin
                repeat (8) @(posedge mclk_i);
                #1;
                chk(wfs_wake_o, 1'b0);
            end
        end
        {in_normal_i, analog_builtin_self_test_i} <= 2'h0;
        cfg_wake(3'h3, 2'h3, 3'h7);
        cfg_wake(3'h5, 2'h1, 3'h1);
        wfs_mcu_model_inst.frame(3'h2);
        wait_on(1);
        chk(to_standby_o, 1'b0);
        in_sleep_i <= 1'b1;
        wfs_mcu_model_inst.frame(3'h1);
        wait_on(0);
        chk(wake_irq_o, 1'b1);
        chk({comm_supply_regulator_o, volt_ref_o, tracker_supplies_o, supervision_en_o},
            {rows[6].comm, rows[6].vref, rows[6].trk, rows[6].sup});
        in_sleep_i <= 1'b0;
        wfs_mcu_model_inst.frame(3'h4);
        wait_on(2);
        chk(to_sleep_o, 1'b0);
        severe_failure_i <= 1'b1;
        wait_on(3);
        chk({standby_regulator_o, pre_regulator_buck_o, pre_regulator_boost_o,
             micro_supply_regulator_o, comm_supply_regulator_o, volt_ref_o,
             tracker_supplies_o, core_adjust_o}, 9'h0);
        chk({wake_timer_en_o, supervision_en_o}, 4'h0);
        chk(reset_out_o, 1'b0);
        chk({safe_state_out_first_o, safe_state_out_second_o, safe_state_control_o}, 3'h0);
        severe_failure_i <= 1'b0;
        wfs_mcu_model_inst.pulse(1'b0);
        repeat (8) @(posedge mclk_i);
        #1;
        chk({wfs_failsafe_o, standby_regulator_o, wfs_wake_o}, 3'h4);
        give_verdict();
    end
endmodule : wfs_ctrl_tb
